// file: logic/fpsc_ctrl.sv
/*
  Shutdown sequencing, overcurrent hiccup and latch, over-temperature response and
  current and temperature readback for a buck regulator. Pins enable_pin, oc_comp_pin and
  ref_at_zero are asynchronous; ADC words, pwm_set and configuration come from core_clk logic.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - default stop on enable low is immediate, both drivers off, no ramp.
// - operation command can gate conversion; soft turn-off is selectable.
// - pmbus soft-off waits 0..127 ms in 1 ms steps before ramping.
// - pmbus soft-stop ramp lasts 1..127 ms in 1 ms steps.
// - turn-off delay exists only in pmbus mode.
// - processor-voltage-pin soft-stop slews reference down at 0.625 mV/us.
// - average current reported in 1/16 A steps.
// - 8-bit current byte in 1/4 A steps.
// - digitized current against warn limit raises overcurrent warning.
// - comparator sampled about 75 ns after set pulse rises.
// - eight total trips start hiccup: enable low 20 ms, then restart.
// - hiccup repeats while the overload persists.
// - overcurrent response is latch or hiccup, hiccup by default.
// - three consecutive trips step duty cap to half, quarter, eighth.
// - below an eighth duty no cut, trips only counted.
// - four clean cycles double the cap back toward nominal.
// - temperature reported in 1 degree steps.
// - 8-bit temperature byte equals temperature minus 40.
// - trip defaults to 125 C; default response disables conversion.
// - automatic restart after temperature falls 25 C below trip.
// - thermal response ignore, inhibit or latch; trip limit programmable.
module fpsc_ctrl
  import fpsc_pkg::*;
#(
  parameter int MS_CYC     = MS_CYC_DFLT,
  parameter int HICCUP_CYC = HICCUP_CYC_DFLT
)
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // asynchronous pins
  input  wire logic        enable_pin,
  input  wire logic        oc_comp_pin,
  input  wire logic        ref_at_zero,
  // switching-cycle timing
  input  wire logic        pwm_set,
  input  wire logic [7:0]  nominal_duty,
  // telemetry words
  input  wire logic [11:0] iout_adc,
  input  wire logic [7:0]  temp_code,
  // configuration
  input  wire logic        mode_pmbus,
  input  wire logic        op_ctrl_en,
  input  wire logic        op_on,
  input  wire logic        soft_off_en,
  input  wire logic [6:0]  off_delay_ms,
  input  wire logic [6:0]  stop_time_ms,
  input  wire logic        oc_resp_latch,
  input  wire logic [1:0]  ot_resp,
  input  wire logic        ot_limit_prog_en,
  input  wire logic [8:0]  ot_limit_prog,
  input  wire logic [11:0] iout_warn_limit,
  input  wire logic        clear_faults,
  // power stage control
  output logic             conv_enable,
  output logic             ref_ramp_active,
  output logic             ref_step,
  output logic      [7:0]  duty_limit,
  // status
  output logic             hiccup_active,
  output logic             oc_latched,
  output logic             ot_fault,
  output logic             oc_warn,
  // readback
  output logic      [11:0] read_iout,
  output logic      [7:0]  load_current_readback,
  output logic      [8:0]  read_temperature,
  output logic      [7:0]  die_heat_readback
);

  fpsc_ctl_t  s_reg;
  fpsc_ctl_t  s_next;
  logic       on_req;
  logic       ms_tick;
  logic       sample_now;
  logic       oc_trip;
  logic       trip_done;
  logic       lim_clear;
  logic [8:0] ot_limit;
  logic [8:0] temp_now;
  logic [9:0] temp_hyst;

  // the off state and hiccup also clear the limiter so a fresh start runs at nominal duty
  assign on_req     = s_reg.en_s2 && (!op_ctrl_en || op_on);
  assign ms_tick    = (s_reg.pre == '0);
  assign sample_now = (s_reg.samp_cnt == 3'h1) && s_reg.conv_en;
  assign oc_trip    = sample_now && s_reg.oc_s2;
  assign trip_done  = oc_trip && (s_reg.trips == OC_TRIP_LIMIT - 4'h1);
  assign ot_limit   = ot_limit_prog_en ? ot_limit_prog : OT_LIMIT_DFLT;
  assign temp_now   = {1'b0, temp_code} + TEMP_OFFSET;
  assign temp_hyst  = {1'b0, temp_now} + OT_HYST;
  assign lim_clear  = (s_reg.state == ST_OFF) || s_reg.hiccup;

  always_comb
  begin
    s_next = s_reg;
    s_next.en_s1    = enable_pin;
    s_next.en_s2    = s_reg.en_s1;
    s_next.oc_s1    = oc_comp_pin;
    s_next.oc_s2    = s_reg.oc_s1;
    s_next.rz_s1    = ref_at_zero;
    s_next.rz_s2    = s_reg.rz_s1;
    s_next.set_d    = pwm_set;
    s_next.ref_step = 1'b0;

    // sample point counted from the rising edge of the set pulse
    if (pwm_set && !s_reg.set_d)
      s_next.samp_cnt = 3'(OC_SAMPLE_CYC);
    else if (s_reg.samp_cnt != 3'h0)
      s_next.samp_cnt = s_reg.samp_cnt - 3'h1;

    if (ms_tick)
      s_next.pre = TMR_W'(MS_CYC - 1);
    else
      s_next.pre = s_reg.pre - 1'b1;

    case (s_reg.state)
      ST_OFF:
      begin
        if (on_req)
        begin
          s_next.state = ST_RUN;
          s_next.trips = 4'h0;
        end
      end
      ST_RUN:
      begin
        if (!on_req)
        begin
          s_next.pre = TMR_W'(MS_CYC - 1);
          if (!soft_off_en)
            s_next.state = ST_OFF;
          else if (!mode_pmbus)
          begin
            s_next.state    = ST_SLEW;
            s_next.slew_cnt = 8'(SLEW_STEP_CYC - 1);
          end
          else if (off_delay_ms != 7'h00)
          begin
            s_next.state   = ST_DLY;
            s_next.ms_left = off_delay_ms;
          end
          else
          begin
            s_next.state   = ST_RAMP;
            s_next.ms_left = (stop_time_ms == 7'h00) ? 7'h01 : stop_time_ms;
          end
        end
      end
      ST_DLY:
      begin
        if (on_req)
          s_next.state = ST_RUN;
        else if (ms_tick)
        begin
          if (s_reg.ms_left == 7'h01)
          begin
            s_next.state   = ST_RAMP;
            s_next.ms_left = (stop_time_ms == 7'h00) ? 7'h01 : stop_time_ms;
          end
          else
            s_next.ms_left = s_reg.ms_left - 7'h01;
        end
      end
      ST_RAMP:
      begin
        // once the ramp starts it runs to the end; re-enable waits for the off state
        if (ms_tick)
        begin
          if (s_reg.ms_left == 7'h01)
            s_next.state = ST_OFF;
          else
            s_next.ms_left = s_reg.ms_left - 7'h01;
        end
      end
      ST_SLEW:
      begin
        if (s_reg.rz_s2)
          s_next.state = ST_OFF;
        else if (s_reg.slew_cnt == 8'h00)
        begin
          s_next.ref_step = 1'b1;
          s_next.slew_cnt = 8'(SLEW_STEP_CYC - 1);
        end
        else
          s_next.slew_cnt = s_reg.slew_cnt - 8'h01;
      end
      default:
        s_next.state = ST_OFF;
    endcase
    s_next.ramp_act = (s_next.state == ST_RAMP) || (s_next.state == ST_SLEW);

    // overcurrent: total trips lead to hiccup or latch
    if (clear_faults && s_reg.oc_lat)
    begin
      s_next.oc_lat = 1'b0;
      s_next.trips  = 4'h0;
    end
    if (s_reg.hiccup)
    begin
      if (s_reg.hic_cnt == '0)
      begin
        s_next.hiccup = 1'b0;
        s_next.trips  = 4'h0;
      end
      else
        s_next.hic_cnt = s_reg.hic_cnt - 1'b1;
    end
    else if (oc_trip && !s_reg.oc_lat)
    begin
      s_next.trips = s_reg.trips + 4'h1;
      if (trip_done)
      begin
        if (oc_resp_latch)
          s_next.oc_lat = 1'b1;
        else
        begin
          s_next.hiccup  = 1'b1;
          s_next.hic_cnt = TMR_W'(HICCUP_CYC - 1);
        end
      end
    end

    // over-temperature; clear requests lose to a trip in the same cycle
    if (clear_faults)
      s_next.ot_lat = 1'b0;
    if (temp_now > ot_limit)
    begin
      if (ot_resp == OT_RESP_INHIBIT)
        s_next.ot_inh = 1'b1;
      else if (ot_resp == OT_RESP_LATCH)
        s_next.ot_lat = 1'b1;
    end
    else if (temp_hyst <= {1'b0, ot_limit} || ot_resp != OT_RESP_INHIBIT)
      s_next.ot_inh = 1'b0;

    s_next.conv_en = (s_next.state != ST_OFF) && !s_next.hiccup && !s_next.oc_lat
                     && !s_next.ot_inh && !s_next.ot_lat;

    // telemetry
    s_next.iout  = iout_adc;
    s_next.ibyte = (iout_adc[11:10] != 2'h0) ? IOUT_BYTE_MAX : iout_adc[9:2];
    s_next.warn  = (iout_adc >= iout_warn_limit);
    s_next.temp  = temp_now;
    s_next.tbyte = temp_code;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s_reg       <= '0;
      s_reg.state <= ST_OFF;
      s_reg.temp  <= TEMP_OFFSET;
    end
    else
      s_reg <= s_next;
  end

  fpsc_duty_limiter u_limiter
  (
    .core_clk     (core_clk),
    .rst          (rst),
    .clear        (lim_clear),
    .sample_valid (sample_now),
    .sample_oc    (s_reg.oc_s2),
    .nominal_duty (nominal_duty),
    .duty_limit   (duty_limit),
    .limit_level  ()
  );

  assign conv_enable           = s_reg.conv_en;
  assign ref_ramp_active       = s_reg.ramp_act;
  assign ref_step              = s_reg.ref_step;
  assign hiccup_active         = s_reg.hiccup;
  assign oc_latched            = s_reg.oc_lat;
  assign ot_fault              = s_reg.ot_inh || s_reg.ot_lat;
  assign oc_warn               = s_reg.warn;
  assign read_iout             = s_reg.iout;
  assign load_current_readback = s_reg.ibyte;
  assign read_temperature      = s_reg.temp;
  assign die_heat_readback     = s_reg.tbyte;

  AST_IMMEDIATE_STOP: assert property (@(posedge core_clk) disable iff (rst)
    (s_reg.state == ST_RUN && !on_req && !soft_off_en) |=> !conv_enable && s_reg.state == ST_OFF)
    else $error("hard stop did not drop enable at once");

  AST_PMBUS_DELAY: assert property (@(posedge core_clk) disable iff (rst)
    (s_reg.state == ST_RUN && !on_req && soft_off_en && mode_pmbus && off_delay_ms != 7'h00)
    |=> s_reg.state == ST_DLY && s_reg.ms_left == $past(off_delay_ms) && conv_enable == $past(conv_enable))
    else $error("soft-off delay not entered");

  AST_NO_DELAY_OTHER_MODE: assert property (@(posedge core_clk) disable iff (rst)
    (s_reg.state == ST_RUN && !on_req && soft_off_en && !mode_pmbus) |=> s_reg.state == ST_SLEW)
    else $error("delay inserted outside pmbus mode");

  AST_RAMP_FLAG: assert property (@(posedge core_clk) disable iff (rst)
    $rose(s_reg.state == ST_RAMP) |-> ref_ramp_active && s_reg.ms_left != 7'h00)
    else $error("ramp started without active flag or length");

  AST_SLEW_SPACING: assert property (@(posedge core_clk) disable iff (rst)
    ref_step |=> (!ref_step)[*8])
    else $error("reference steps closer than slew rate allows");

  AST_HICCUP_OFF: assert property (@(posedge core_clk) disable iff (rst)
    $rose(hiccup_active) |-> (hiccup_active && !conv_enable)[*8])
    else $error("hiccup did not hold conversion off");

  AST_HICCUP_CLEARS: assert property (@(posedge core_clk) disable iff (rst)
    $fell(hiccup_active) |-> s_reg.trips == 4'h0)
    else $error("trip count survived hiccup restart");

  AST_LATCH_HOLDS: assert property (@(posedge core_clk) disable iff (rst)
    (oc_latched && !clear_faults) |=> oc_latched && !conv_enable)
    else $error("latched overcurrent released without clear");

  AST_WARN_COMPARE: assert property (@(posedge core_clk) disable iff (rst)
    oc_warn == (read_iout >= $past(iout_warn_limit)))
    else $error("warning disagrees with reported current");

  AST_CURRENT_BYTE: assert property (@(posedge core_clk) disable iff (rst)
    read_iout[11:10] == 2'h0 |-> load_current_readback == read_iout[9:2])
    else $error("current byte not quarter-amp scaled");

  AST_TEMP_OFFSET: assert property (@(posedge core_clk) disable iff (rst)
    read_temperature == {1'b0, die_heat_readback} + TEMP_OFFSET)
    else $error("temperature byte offset wrong");

  AST_OT_INHIBIT: assert property (@(posedge core_clk) disable iff (rst)
    (temp_now > ot_limit && ot_resp == OT_RESP_INHIBIT) |=> !conv_enable && ot_fault)
    else $error("over-temperature did not inhibit conversion");

  AST_OT_HYSTERESIS: assert property (@(posedge core_clk) disable iff (rst)
    (s_reg.ot_inh && ot_resp == OT_RESP_INHIBIT && temp_hyst > {1'b0, ot_limit}) |=> s_reg.ot_inh)
    else $error("thermal restart before hysteresis reached");

endmodule

// file: logic/fpsc_duty_limiter.sv
/*
  Pulse-by-pulse duty limiter: steps the duty cap down on runs of overcurrent samples
  and back up on runs of clean samples. Expects one sample strobe per switching cycle.
*/
`timescale 1ns/1ps
module fpsc_duty_limiter
  import fpsc_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // samples
  input  wire logic       clear,
  input  wire logic       sample_valid,
  input  wire logic       sample_oc,
  input  wire logic [7:0] nominal_duty,
  // limit
  output logic      [7:0] duty_limit,
  output logic      [1:0] limit_level
);

  fpsc_lim_t  s_reg;
  fpsc_lim_t  s_next;
  logic [7:0] cap;

  always_comb
  begin
    s_next = s_reg;
    if (clear)
    begin
      s_next.level  = 2'h0;
      s_next.consec = 2'h0;
      s_next.below  = 3'h0;
    end
    else if (sample_valid)
    begin
      if (sample_oc)
      begin
        s_next.below = 3'h0;
        // below an eighth there is nothing to cut; cycles are only counted upstream
        if (nominal_duty >= DUTY_EIGHTH && s_reg.level != 2'h3)
        begin
          if (s_reg.consec == OC_CONSEC_STEP - 2'h1)
          begin
            s_next.level  = s_reg.level + 2'h1;
            s_next.consec = 2'h0;
          end
          else
            s_next.consec = s_reg.consec + 2'h1;
        end
      end
      else
      begin
        s_next.consec = 2'h0;
        if (s_reg.level != 2'h0)
        begin
          if (s_reg.below == OC_RECOVER_RUN - 3'h1)
          begin
            s_next.level = s_reg.level - 2'h1;
            s_next.below = 3'h0;
          end
          else
            s_next.below = s_reg.below + 3'h1;
        end
      end
    end
    case (s_next.level)
      2'h1:    cap = DUTY_HALF;
      2'h2:    cap = DUTY_QUARTER;
      2'h3:    cap = DUTY_EIGHTH;
      default: cap = nominal_duty;
    endcase
    s_next.duty = (nominal_duty < cap) ? nominal_duty : cap;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign duty_limit  = s_reg.duty;
  assign limit_level = s_reg.level;

  AST_DUTY_CAP_EIGHTH: assert property (@(posedge core_clk) disable iff (rst)
    limit_level == 2'h3 |-> duty_limit <= DUTY_EIGHTH)
    else $error("duty above an eighth at deepest limit level");

  AST_SMALL_DUTY_UNCUT: assert property (@(posedge core_clk) disable iff (rst)
    nominal_duty < DUTY_EIGHTH |=> duty_limit == $past(nominal_duty))
    else $error("duty below an eighth was reduced");

  AST_RECOVER_AFTER_FOUR: assert property (@(posedge core_clk) disable iff (rst)
    (sample_valid && !sample_oc && !clear && limit_level != 2'h0 && s_reg.below == 3'h3)
    |=> limit_level == $past(limit_level) - 2'h1)
    else $error("limit did not relax after four clean cycles");

endmodule

// file: logic/fpsc_pkg.sv
/*
  Constants and state types for the buck shutdown and fault-protection controller.
  Assumes a 10 MHz core clock; every timing count is derived from the period below.
*/
package fpsc_pkg;

  localparam int CLK_PERIOD_NS   = 100;
  localparam int TIME_1MS_NS     = 1000000;
  localparam int MS_CYC_DFLT     = TIME_1MS_NS / CLK_PERIOD_NS;
  localparam int HICCUP_MS       = 20;
  localparam int HICCUP_CYC_DFLT = HICCUP_MS * MS_CYC_DFLT;
  localparam int TMR_W           = 18;

  // comparator sample point after the set pulse rises; a point in time, so round down, at least one cycle
  localparam int OC_SAMPLE_NS  = 75;
  localparam int OC_SAMPLE_CYC = (OC_SAMPLE_NS / CLK_PERIOD_NS < 1) ? 1 : OC_SAMPLE_NS / CLK_PERIOD_NS;

  // soft-stop slew of 0.625 mV/us, expressed in uV/us; reference step size is a plain default
  localparam int SLEW_UV_PER_US = 625;
  localparam int VREF_LSB_UV    = 5000;
  localparam int SLEW_STEP_NS   = VREF_LSB_UV * 1000 / SLEW_UV_PER_US;
  localparam int SLEW_STEP_CYC  = (SLEW_STEP_NS / CLK_PERIOD_NS < 1) ? 1 : SLEW_STEP_NS / CLK_PERIOD_NS;

  localparam logic [3:0] OC_TRIP_LIMIT  = 4'h8;
  localparam logic [1:0] OC_CONSEC_STEP = 2'h3;
  localparam logic [2:0] OC_RECOVER_RUN = 3'h4;

  // duty as a fraction of 256
  localparam logic [7:0] DUTY_HALF    = 8'h80;
  localparam logic [7:0] DUTY_QUARTER = 8'h40;
  localparam logic [7:0] DUTY_EIGHTH  = 8'h20;

  localparam logic [8:0] TEMP_OFFSET   = 9'h028;
  localparam logic [8:0] OT_LIMIT_DFLT = 9'h07D;
  localparam logic [9:0] OT_HYST       = 10'h019;

  localparam logic [1:0] OT_RESP_INHIBIT = 2'h0;
  localparam logic [1:0] OT_RESP_IGNORE  = 2'h1;
  localparam logic [1:0] OT_RESP_LATCH   = 2'h2;

  localparam logic [7:0] IOUT_BYTE_MAX = 8'hFF;

  typedef enum logic [2:0] {ST_OFF, ST_RUN, ST_DLY, ST_RAMP, ST_SLEW} fpsc_state_t;

  typedef struct packed {
    logic [1:0] level;
    logic [1:0] consec;
    logic [2:0] below;
    logic [7:0] duty;
  } fpsc_lim_t;

  typedef struct packed {
    logic             en_s1;
    logic             en_s2;
    logic             oc_s1;
    logic             oc_s2;
    logic             rz_s1;
    logic             rz_s2;
    logic             set_d;
    fpsc_state_t      state;
    logic [2:0]       samp_cnt;
    logic [TMR_W-1:0] pre;
    logic [6:0]       ms_left;
    logic [7:0]       slew_cnt;
    logic [3:0]       trips;
    logic             hiccup;
    logic [TMR_W-1:0] hic_cnt;
    logic             oc_lat;
    logic             ot_inh;
    logic             ot_lat;
    logic             conv_en;
    logic             ramp_act;
    logic             ref_step;
    logic [11:0]      iout;
    logic [7:0]       ibyte;
    logic             warn;
    logic [8:0]       temp;
    logic [7:0]       tbyte;
  } fpsc_ctl_t;

endpackage

// file: tb/fpsc_ctrl_tb.sv
/*
  Self-checking bench for fpsc_ctrl with an integer model of trips, duty cap and readback.
  Assumes shortened counts of 10 cycles per ms and a 50-cycle hiccup.
*/
`timescale 1ns/1ps
`define CK(g, e) \
  begin \
    checks++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end
module fpsc_ctrl_tb
  import fpsc_pkg::*;
;
  localparam int MSC = 10;
  localparam int HIC = 50;
  logic core_clk = 1'b0, rst = 1'b1, clear_req = 1'b0, clear_faults;
  logic enable_pin = 1'b0, oc_comp_pin = 1'b0, ref_at_zero = 1'b0, pwm_set = 1'b0;
  logic mode_pmbus = 1'b1, op_ctrl_en = 1'b0, op_on = 1'b1, soft_off_en = 1'b0;
  logic oc_resp_latch = 1'b0, ot_limit_prog_en = 1'b0;
  logic [1:0] ot_resp = OT_RESP_INHIBIT;
  logic [6:0] off_delay_ms = 7'h00, stop_time_ms = 7'h01;
  logic [7:0] nominal_duty = 8'h80, temp_code = 8'h19, duty_limit, load_current_readback, die_heat_readback;
  logic [8:0] ot_limit_prog = 9'h050, read_temperature;
  logic [11:0] iout_adc = 12'h000, iout_warn_limit = 12'h800, read_iout;
  logic conv_enable, ref_ramp_active, ref_step, hiccup_active, oc_latched, ot_fault, oc_warn;
  int n_errors = 0, checks = 0, seed = 51344, c;
  int m_trips = 0, m_lvl = 0, m_cons = 0, m_clean = 0;

  always #50 core_clk = ~core_clk;

  fpsc_host_model host_u (.core_clk(core_clk), .rst(rst), .clear_req(clear_req), .clear_faults(clear_faults));

  fpsc_ctrl #(.MS_CYC(MSC), .HICCUP_CYC(HIC)) dut_u (
    .core_clk(core_clk), .rst(rst), .enable_pin(enable_pin), .oc_comp_pin(oc_comp_pin),
    .ref_at_zero(ref_at_zero), .pwm_set(pwm_set), .nominal_duty(nominal_duty), .iout_adc(iout_adc),
    .temp_code(temp_code), .mode_pmbus(mode_pmbus), .op_ctrl_en(op_ctrl_en), .op_on(op_on),
    .soft_off_en(soft_off_en), .off_delay_ms(off_delay_ms), .stop_time_ms(stop_time_ms),
    .oc_resp_latch(oc_resp_latch), .ot_resp(ot_resp), .ot_limit_prog_en(ot_limit_prog_en),
    .ot_limit_prog(ot_limit_prog), .iout_warn_limit(iout_warn_limit), .clear_faults(clear_faults),
    .conv_enable(conv_enable), .ref_ramp_active(ref_ramp_active), .ref_step(ref_step),
    .duty_limit(duty_limit), .hiccup_active(hiccup_active), .oc_latched(oc_latched), .ot_fault(ot_fault),
    .oc_warn(oc_warn), .read_iout(read_iout), .load_current_readback(load_current_readback),
    .read_temperature(read_temperature), .die_heat_readback(die_heat_readback));

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic conclude();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wait_ce(input logic v, input int lim);
    int i = 0;
    while (conv_enable !== v && i < lim)
    begin
      cyc(1);
      i++;
    end
    `CK(conv_enable, v)
    if (conv_enable !== v)
      conclude();
  endtask

  task automatic wait_step(output int n);
    n = 0;
    do
    begin
      cyc(1);
      n++;
    end
    while (ref_step !== 1'b1 && n < 200);
    if (ref_step !== 1'b1)
    begin
      n_errors++;
      conclude();
    end
  endtask

  task automatic clear();
    clear_req <= 1'b1;
    cyc(1);
    clear_req <= 1'b0;
    cyc(4);
  endtask

  // model cap halves per level; level 0 leaves the nominal duty alone
  function automatic logic [7:0] m_duty();
    int cap = 256 >> m_lvl;
    return (m_lvl == 0 || nominal_duty < cap) ? nominal_duty : cap[7:0];
  endfunction

  // one set pulse per 16-cycle switching period; comparator settles before the first one
  task automatic pulses(input int n, input logic oc);
    oc_comp_pin <= oc;
    cyc(4);
    repeat (n)
    begin
      pwm_set <= 1'b1;
      cyc(2);
      pwm_set <= 1'b0;
      cyc(14);
      if (oc && m_trips < 8)
      begin
        m_trips++;
        m_clean = 0;
        m_cons++;
        if (m_cons == 3 && m_lvl < 3 && nominal_duty >= 8'h20)
        begin
          m_lvl++;
          m_cons = 0;
        end
        if (m_trips == 8)
        begin
          m_lvl = 0;
          m_cons = 0;
        end
      end
      else if (!oc)
      begin
        m_cons = 0;
        m_clean++;
        if (m_clean == 4 && m_lvl > 0)
        begin
          m_lvl--;
          m_clean = 0;
        end
      end
    end
    `CK(duty_limit, m_duty())
  endtask

  initial
  begin
    cyc(8);
    rst <= 1'b0;
    cyc(2);
    `CK(conv_enable, 1'b0)
    repeat (16)
    begin
      iout_adc <= 12'($random(seed));
      temp_code <= 8'($random(seed));
      iout_warn_limit <= 12'($random(seed));
      cyc(3);
      `CK(read_iout, iout_adc)
      `CK(load_current_readback, (iout_adc > 12'h3FF) ? 8'hFF : iout_adc[9:2])
      `CK(oc_warn, iout_adc >= iout_warn_limit)
      `CK(read_temperature, {1'b0, temp_code} + 9'h028)
      `CK(die_heat_readback, temp_code)
    end
    temp_code <= 8'h19;
    $display("readback done");
    enable_pin <= 1'b1;
    wait_ce(1'b1, 8);
    enable_pin <= 1'b0;
    wait_ce(1'b0, 4);
    op_ctrl_en <= 1'b1;
    enable_pin <= 1'b1;
    wait_ce(1'b1, 8);
    op_on <= 1'b0;
    wait_ce(1'b0, 4);
    op_on <= 1'b1;
    wait_ce(1'b1, 6);
    $display("enable and stop done");
    soft_off_en <= 1'b1;
    off_delay_ms <= 7'h04;
    stop_time_ms <= 7'h03;
    enable_pin <= 1'b0;
    cyc(30);
    `CK({conv_enable, ref_ramp_active}, 2'b10)
    cyc(25);
    `CK({conv_enable, ref_ramp_active}, 2'b11)
    cyc(30);
    `CK(conv_enable, 1'b0)
    mode_pmbus <= 1'b0;
    enable_pin <= 1'b1;
    wait_ce(1'b1, 8);
    enable_pin <= 1'b0;
    wait_step(c);
    `CK(c > 77 && c < 90, 1'b1)
    wait_step(c);
    `CK(c, SLEW_STEP_CYC)
    `CK(ref_ramp_active, 1'b1)
    ref_at_zero <= 1'b1;
    wait_ce(1'b0, 8);
    ref_at_zero <= 1'b0;
    soft_off_en <= 1'b0;
    mode_pmbus <= 1'b1;
    enable_pin <= 1'b1;
    wait_ce(1'b1, 8);
    $display("soft stop done");
    nominal_duty <= 8'hC0;
    pulses(3, 1'b1);
    pulses(3, 1'b1);
    pulses(4, 1'b0);
    pulses(4, 1'b0);
    pulses(2, 1'b1);
    `CK(hiccup_active, 1'b1)
    cyc(30);
    `CK(conv_enable, 1'b0)
    cyc(15);
    `CK(hiccup_active, 1'b0)
    m_trips = 0;
    pulses(7, 1'b1);
    `CK(hiccup_active, 1'b0)
    pulses(1, 1'b1);
    `CK(hiccup_active, 1'b1)
    oc_comp_pin <= 1'b0;
    cyc(60);
    m_trips = 0;
    oc_resp_latch <= 1'b1;
    nominal_duty <= 8'h10;
    pulses(3, 1'b1);
    pulses(5, 1'b1);
    cyc(100);
    `CK({oc_latched, hiccup_active, conv_enable}, 3'b100)
    clear();
    `CK(oc_latched, 1'b0)
    wait_ce(1'b1, 8);
    oc_comp_pin <= 1'b0;
    oc_resp_latch <= 1'b0;
    $display("overcurrent done");
    temp_code <= 8'h56;
    cyc(6);
    `CK(ot_fault, 1'b1)
    wait_ce(1'b0, 4);
    temp_code <= 8'h3D;
    cyc(6);
    `CK(ot_fault, 1'b1)
    temp_code <= 8'h3C;
    wait_ce(1'b1, 8);
    ot_resp <= OT_RESP_LATCH;
    temp_code <= 8'h56;
    cyc(6);
    temp_code <= 8'h19;
    cyc(6);
    `CK({ot_fault, conv_enable}, 2'b10)
    clear();
    `CK(ot_fault, 1'b0)
    wait_ce(1'b1, 8);
    ot_resp <= OT_RESP_IGNORE;
    temp_code <= 8'h56;
    cyc(6);
    `CK({ot_fault, conv_enable}, 2'b01)
    ot_resp <= 2'h3;
    cyc(6);
    `CK({ot_fault, conv_enable}, 2'b01)
    ot_resp <= OT_RESP_INHIBIT;
    ot_limit_prog_en <= 1'b1;
    temp_code <= 8'h28;
    cyc(6);
    `CK(ot_fault, 1'b0)
    temp_code <= 8'h29;
    cyc(6);
    `CK(ot_fault, 1'b1)
    temp_code <= 8'h0F;
    wait_ce(1'b1, 8);
    $display("thermal done");
    conclude();
  end
endmodule

// file: tb/fpsc_host_model.sv
/*
  Host controller model: sends one fault clear after start-up and one on each bench request.
  Assumes the same core clock and reset as the controller it talks to.
*/
`timescale 1ns/1ps
module fpsc_host_model (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // bench request
  input  wire logic clear_req,
  // command strobe
  output logic      clear_faults
);
  logic boot_done;

  // a start-up clear goes out in the first cycle after reset, before the controller can leave the off state
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      boot_done    <= 1'b0;
      clear_faults <= 1'b0;
    end
    else
    begin
      clear_faults <= !boot_done || clear_req;
      boot_done    <= 1'b1;
    end
  end
endmodule
